/* File: hdl/obd_pkg.sv */
package obd_pkg;
	// Option byte layout
	localparam logic [7:0] OBD_OPT_ERASED = 8'hff;
	localparam int OBD_BSZ_LSB = 0;
	localparam int OBD_BSZ_W = 3;
	localparam int OBD_BO_EN_BIT = 7;
	localparam int OBD_BO_THR_LSB = 4;
	localparam int OBD_BO_THR_W = 2;
	localparam int OBD_BO_BLK_BIT = 3;
	localparam int OBD_BO_RST_BIT = 2;
	localparam int OBD_WD_LSB = 4;
	localparam int OBD_WD_W = 4;
	// Copy widths and reset values
	localparam int OBD_BO_CPY_W = 5;
	localparam logic [2:0] OBD_BSZ_RST = 3'h7;
	localparam logic [4:0] OBD_BO_CPY_RST = 5'h1f;
	localparam logic [3:0] OBD_WD_RST = 4'hf;
	localparam logic [0:0] OBD_POR_PEND_RST = 1'h1;
	// Boot size codes and region sizes in kilobytes
	localparam logic [2:0] OBD_BSZ_NONE = 3'h7;
	localparam logic [2:0] OBD_BSZ_1K = 3'h6;
	localparam logic [2:0] OBD_BSZ_2K = 3'h5;
	localparam logic [2:0] OBD_BSZ_3K = 3'h4;
	localparam logic [4:0] OBD_FLASH_KB = 5'h12;
	localparam logic [2:0] OBD_BOOT_KB_0 = 3'h0;
	localparam logic [2:0] OBD_BOOT_KB_1 = 3'h1;
	localparam logic [2:0] OBD_BOOT_KB_2 = 3'h2;
	localparam logic [2:0] OBD_BOOT_KB_3 = 3'h3;
	localparam logic [2:0] OBD_BOOT_KB_4 = 3'h4;
	// Watchdog start-up codes
	localparam logic [3:0] OBD_WD_OFF = 4'hf;
	localparam logic [3:0] OBD_WD_STOP_IDLE = 4'h5;
	// Sequencer states
	typedef enum logic [1:0] {
		OBD_LOAD = 2'b01,
		OBD_RUN = 2'b10
	} obd_state_e;
endpackage

/* File: hdl/obd_sfr_copy.sv */
`timescale 1ns/10ps
`default_nettype none
// Software-visible copy of option bits
module obd_sfr_copy #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic load,
	input wire logic [W-1:0] load_data,
	input wire logic wr,
	input wire logic [W-1:0] wr_data,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] val;
	} obd_cpy_s;

	obd_cpy_s cpy_q;
	obd_cpy_s cpy_d;

	// Reload beats a software write
	always_comb begin
		cpy_d = cpy_q;
		if (load) begin
			cpy_d.val = load_data;
		end else if (wr) begin
			cpy_d.val = wr_data;
		end
	end

	// Copy register
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cpy_q.val <= RST;
		end else begin
			cpy_q <= cpy_d;
		end
	end

	assign q = cpy_q.val;
endmodule
`default_nettype wire

/* File: hdl/obd_top.sv */
`timescale 1ns/10ps
`default_nettype none
module obd_top
	import obd_pkg::*;
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic por_rst_n,
	input wire logic nv_valid,
	input wire logic nv_erased,
	input wire logic [7:0] nv_boot_opt,
	input wire logic [7:0] nv_bo_opt,
	input wire logic [7:0] nv_wd_opt,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_wr_boot,
	input wire logic sfr_wr_bo,
	input wire logic sfr_wr_wd,
	input wire logic brownout_pin,
	input wire logic core_idle,
	input wire logic iap_req,
	output logic cfg_ok,
	output logic [7:0] sfr_boot_rdata,
	output logic [7:0] sfr_bo_rdata,
	output logic [7:0] sfr_wd_rdata,
	output logic [2:0] boot_region_size,
	output logic [2:0] boot_region_kb,
	output logic [4:0] app_region_kb,
	output logic brownout_detect_on,
	output logic [1:0] brownout_threshold_select,
	output logic brownout_blocks_flash_write,
	output logic brownout_reset_on,
	output logic [3:0] watchdog_startup_mode,
	output logic wdt_reset_on,
	output logic wdt_stop_in_idle,
	output logic wdt_general_timer,
	output logic wdt_count_en,
	output logic brownout_reset_req,
	output logic flash_write_ok,
	output logic iap_grant,
	output logic iap_refused
);
	typedef struct packed {
		obd_state_e state;
		logic bo_meta;
		logic bo_sync;
		logic [2:0] boot_kb;
		logic [4:0] app_kb;
		logic wd_rst;
		logic wd_stop;
		logic wd_gp;
		logic wd_cnt;
		logic bo_rst_req;
		logic flash_ok;
		logic grant;
		logic refused;
	} obd_st_s;

	obd_st_s st_q;
	obd_st_s st_d;

	// Option bytes after the blank check
	logic [7:0] boot_opt;
	logic [7:0] bo_opt;
	logic [7:0] wd_opt;

	// Load strobes and copy outputs
	logic load_any;
	logic load_por;
	logic [0:0] por_pend;
	logic [2:0] bsz_cpy;
	logic [4:0] bo_cpy;
	logic [3:0] wd_cpy;

	// Brown-out fields in copy order
	logic [4:0] bo_new;
	logic [4:0] bo_wr;
	logic sw_ok;

	// erased storage
	// Blank storage presents all ones
	assign boot_opt = nv_erased ? OBD_OPT_ERASED : nv_boot_opt;
	assign bo_opt = nv_erased ? OBD_OPT_ERASED : nv_bo_opt;
	assign wd_opt = nv_erased ? OBD_OPT_ERASED : nv_wd_opt;

	// reserved bits dropped
	// Only defined fields enter the copies
	assign bo_new = {
		bo_opt[OBD_BO_EN_BIT],
		bo_opt[OBD_BO_THR_LSB +: OBD_BO_THR_W],
		bo_opt[OBD_BO_BLK_BIT],
		bo_opt[OBD_BO_RST_BIT]
	};
	assign bo_wr = {
		sfr_wdata[OBD_BO_EN_BIT],
		sfr_wdata[OBD_BO_THR_LSB +: OBD_BO_THR_W],
		sfr_wdata[OBD_BO_BLK_BIT],
		sfr_wdata[OBD_BO_RST_BIT]
	};

	// reload after reset
	// One load pulse once storage is readable
	assign load_any = (st_q.state == OBD_LOAD) && nv_valid;
	assign load_por = load_any && por_pend[0];
	// Writes wait until the copies hold options
	assign sw_ok = (st_q.state == OBD_RUN);

	// Marks a pending power-on reload
	obd_sfr_copy #(
		.W(1),
		.RST(OBD_POR_PEND_RST)
	) u_por_pend (
		.core_clk(core_clk),
		.rst_n(por_rst_n),
		.load(load_any),
		.load_data(1'b0),
		.wr(1'b0),
		.wr_data(1'b0),
		.q(por_pend)
	);

	// Boot size copy, any reset
	obd_sfr_copy #(
		.W(OBD_BSZ_W),
		.RST(OBD_BSZ_RST)
	) u_bsz (
		.core_clk(core_clk),
		.rst_n(arst_n),
		.load(load_any),
		.load_data(boot_opt[OBD_BSZ_LSB +: OBD_BSZ_W]),
		.wr(sfr_wr_boot && sw_ok),
		.wr_data(sfr_wdata[OBD_BSZ_LSB +: OBD_BSZ_W]),
		.q(bsz_cpy)
	);

	// Brown-out copy, power-on reset only
	obd_sfr_copy #(
		.W(OBD_BO_CPY_W),
		.RST(OBD_BO_CPY_RST)
	) u_bo (
		.core_clk(core_clk),
		.rst_n(por_rst_n),
		.load(load_por),
		.load_data(bo_new),
		.wr(sfr_wr_bo && sw_ok),
		.wr_data(bo_wr),
		.q(bo_cpy)
	);

	// Watchdog copy, any reset
	obd_sfr_copy #(
		.W(OBD_WD_W),
		.RST(OBD_WD_RST)
	) u_wd (
		.core_clk(core_clk),
		.rst_n(arst_n),
		.load(load_any),
		.load_data(wd_opt[OBD_WD_LSB +: OBD_WD_W]),
		.wr(sfr_wr_wd && sw_ok),
		.wr_data(sfr_wdata[OBD_WD_LSB +: OBD_WD_W]),
		.q(wd_cpy)
	);

	// Field views of the copies
	assign boot_region_size = bsz_cpy;
	assign brownout_detect_on = bo_cpy[4];
	assign brownout_threshold_select = bo_cpy[3:2];
	assign brownout_blocks_flash_write = bo_cpy[1];
	assign brownout_reset_on = bo_cpy[0];
	assign watchdog_startup_mode = wd_cpy;

	// Read back, reserved bits as ones
	always_comb begin
		// Boot size byte
		sfr_boot_rdata = OBD_OPT_ERASED;
		sfr_boot_rdata[OBD_BSZ_LSB +: OBD_BSZ_W] = bsz_cpy;

		// Brown-out byte
		sfr_bo_rdata = OBD_OPT_ERASED;
		sfr_bo_rdata[OBD_BO_EN_BIT] = bo_cpy[4];
		sfr_bo_rdata[OBD_BO_THR_LSB +: OBD_BO_THR_W] = bo_cpy[3:2];
		sfr_bo_rdata[OBD_BO_BLK_BIT] = bo_cpy[1];
		sfr_bo_rdata[OBD_BO_RST_BIT] = bo_cpy[0];

		// Watchdog byte
		sfr_wd_rdata = OBD_OPT_ERASED;
		sfr_wd_rdata[OBD_WD_LSB +: OBD_WD_W] = wd_cpy;
	end

	// Next-state logic
	always_comb begin
		st_d = st_q;
		// Brown-out level through two flops
		st_d.bo_meta = brownout_pin;
		st_d.bo_sync = st_q.bo_meta;

		case (st_q.state)
			OBD_LOAD: begin
				if (nv_valid) begin
					st_d.state = OBD_RUN;
				end
			end
			OBD_RUN: begin
				st_d.state = OBD_RUN;
			end
			default: begin
				st_d.state = OBD_LOAD;
			end
		endcase

		case (bsz_cpy)
			OBD_BSZ_NONE: st_d.boot_kb = OBD_BOOT_KB_0;
			OBD_BSZ_1K: st_d.boot_kb = OBD_BOOT_KB_1;
			OBD_BSZ_2K: st_d.boot_kb = OBD_BOOT_KB_2;
			OBD_BSZ_3K: st_d.boot_kb = OBD_BOOT_KB_3;
			default: st_d.boot_kb = OBD_BOOT_KB_4;
		endcase
		st_d.app_kb = OBD_FLASH_KB - {2'h0, st_d.boot_kb};

		st_d.wd_gp = (wd_cpy == OBD_WD_OFF);
		st_d.wd_rst = (wd_cpy != OBD_WD_OFF);
		st_d.wd_stop = (wd_cpy == OBD_WD_STOP_IDLE);
		st_d.wd_cnt = !(st_d.wd_stop && core_idle);

		st_d.bo_rst_req = bo_cpy[4] && bo_cpy[0]
			&& st_q.bo_sync;
		st_d.flash_ok = !(bo_cpy[4] && bo_cpy[1]
			&& st_q.bo_sync);

		// One-cycle answer to a flash request
		st_d.grant = iap_req && sw_ok && st_d.flash_ok;
		st_d.refused = iap_req && !(sw_ok && st_d.flash_ok);
	end

	// State register
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q.state <= OBD_LOAD;
			st_q.bo_meta <= 1'b0;
			st_q.bo_sync <= 1'b0;
			// Decodes match the reset copies
			st_q.boot_kb <= OBD_BOOT_KB_0;
			st_q.app_kb <= OBD_FLASH_KB;
			st_q.wd_rst <= 1'b0;
			st_q.wd_stop <= 1'b0;
			st_q.wd_gp <= 1'b1;
			st_q.wd_cnt <= 1'b1;
			// No brown-out effect, no answer
			st_q.bo_rst_req <= 1'b0;
			st_q.flash_ok <= 1'b1;
			st_q.grant <= 1'b0;
			st_q.refused <= 1'b0;
		end else begin
			st_q <= st_d;
		end
	end

	// Registered outputs, load state
	assign cfg_ok = (st_q.state == OBD_RUN);

	// Decoded region sizes
	assign boot_region_kb = st_q.boot_kb;
	assign app_region_kb = st_q.app_kb;

	// Watchdog start-up decode
	assign wdt_reset_on = st_q.wd_rst;
	assign wdt_stop_in_idle = st_q.wd_stop;
	assign wdt_general_timer = st_q.wd_gp;
	assign wdt_count_en = st_q.wd_cnt;

	// Brown-out effects
	assign brownout_reset_req = st_q.bo_rst_req;
	assign flash_write_ok = st_q.flash_ok;

	// Flash request answer
	assign iap_grant = st_q.grant;
	assign iap_refused = st_q.refused;
endmodule
`default_nettype wire

/* File: tb/obd_top_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module obd_top_monitor (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic iap_req,
	input wire logic [2:0] boot_region_size,
	input wire logic [2:0] boot_region_kb,
	input wire logic [4:0] app_region_kb,
	input wire logic brownout_detect_on,
	input wire logic brownout_blocks_flash_write,
	input wire logic brownout_reset_on,
	input wire logic brownout_reset_req,
	input wire logic flash_write_ok,
	input wire logic [3:0] watchdog_startup_mode,
	input wire logic wdt_general_timer,
	input wire logic wdt_stop_in_idle,
	input wire logic wdt_reset_on,
	input wire logic iap_grant,
	input wire logic iap_refused
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	// Inhibit clear for two samples
	sequence s_blk_clear;
		!brownout_blocks_flash_write [*2];
	endsequence
	// Region split
	a_app_sum: assert property (
		5'(boot_region_kb) + app_region_kb == 5'h12)
		else $error("region sizes do not add up");
	a_boot_none: assert property (
		boot_region_size == 3'h7 |=> boot_region_kb == 3'h0)
		else $error("boot region not empty");
	a_boot_four: assert property (
		!boot_region_size[2] |=> boot_region_kb == 3'h4)
		else $error("boot region not four");
	// Watchdog modes
	a_wd_off: assert property (
		watchdog_startup_mode == 4'hf
		|=> wdt_general_timer && !wdt_reset_on)
		else $error("watchdog not free timer");
	a_wd_idle: assert property (
		watchdog_startup_mode == 4'h5
		|=> wdt_stop_in_idle && wdt_reset_on)
		else $error("watchdog idle stop wrong");
	a_wd_other: assert property (
		watchdog_startup_mode != 4'hf
		&& watchdog_startup_mode != 4'h5
		|=> wdt_reset_on && !wdt_stop_in_idle)
		else $error("watchdog keep running wrong");
	// Brown-out effects
	a_flash_allowed: assert property (s_blk_clear |-> flash_write_ok)
		else $error("flash write blocked");
	a_bo_reset: assert property (
		brownout_reset_req
		|-> $past(brownout_reset_on) && $past(brownout_detect_on))
		else $error("brown-out reset not enabled");
	a_iap_answer: assert property (iap_req |=> iap_grant != iap_refused)
		else $error("flash request unanswered");
endmodule
bind obd_top obd_top_monitor u_mon (.*);
`default_nettype wire

/* File: tb/obd_nv_model.sv */
`timescale 1ns/10ps
`default_nettype none
module obd_nv_model (
	input wire logic core_clk,
	input wire logic erase,
	input wire logic slow,
	input wire logic [7:0] boot_val,
	input wire logic [7:0] bo_val,
	input wire logic [7:0] wd_val,
	output logic nv_valid,
	output logic nv_erased,
	output logic [7:0] nv_boot_opt,
	output logic [7:0] nv_bo_opt,
	output logic [7:0] nv_wd_opt
);
	// Readable a cycle after slow drops
	always @(posedge core_clk) nv_valid <= !slow;
	assign nv_erased = erase;
	assign nv_boot_opt = erase ? 8'hff : boot_val | 8'hf8;
	assign nv_bo_opt = erase ? 8'hff : bo_val | 8'h43;
	assign nv_wd_opt = erase ? 8'hff : wd_val | 8'h0f;
endmodule
`default_nettype wire

/* File: tb/tb_option_byte_decoder.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_option_byte_decoder;
	import obd_pkg::*;
	logic core_clk = 0, arst_n = 0, por_rst_n = 0, erase = 1, slow = 1;
	logic sfr_wr_boot = 0, sfr_wr_bo = 0, sfr_wr_wd = 0, iap_req = 0;
	logic brownout_pin = 0, core_idle = 0, nv_valid, nv_erased, cfg_ok;
	logic [7:0] sfr_wdata = 0, boot_val = 8'h05, bo_val = 8'h8c;
	logic [7:0] wd_val = 8'h5f, nv_boot_opt, nv_bo_opt, nv_wd_opt;
	logic brownout_detect_on, brownout_blocks_flash_write, iap_refused;
	logic brownout_reset_on, wdt_reset_on, wdt_stop_in_idle, wdt_count_en;
	logic wdt_general_timer, brownout_reset_req, flash_write_ok, iap_grant;
	logic [7:0] sfr_boot_rdata, sfr_bo_rdata, sfr_wd_rdata;
	logic [2:0] boot_region_size, boot_region_kb, e;
	logic [4:0] app_region_kb;
	logic [1:0] brownout_threshold_select;
	logic [3:0] watchdog_startup_mode;
	int n_mismatch = 0, num_checks = 0;
	obd_top dut (.*);
	obd_nv_model u_nv (.*);
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#5;
	endtask
	task automatic chk(input logic [7:0] s, input logic [7:0] x);
		num_checks++;
		if (s !== x) begin
			n_mismatch++;
			$display("mismatch %0t seen %h want %h", $time, s, x);
		end
	endtask
	// Software copy write, settled two edges on
	task automatic wr(input int s, input logic [7:0] d);
		sfr_wdata = d;
		sfr_wr_boot = (s == 0);
		sfr_wr_bo = (s == 1);
		sfr_wr_wd = (s == 2);
		cyc(1);
		{sfr_wr_boot, sfr_wr_bo, sfr_wr_wd} = 3'h0;
		cyc(2);
	endtask
	task automatic self_flash_programming(input logic g);
		iap_req = 1;
		cyc(1);
		iap_req = 0;
		chk({iap_grant, iap_refused}, {g, !g});
	endtask
	task automatic summarize();
		if (n_mismatch == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial forever #25 core_clk = ~core_clk;
	// Watchdog
	initial begin
		#100000;
		n_mismatch++;
		summarize();
	end
	initial begin
		cyc(6);
		{arst_n, por_rst_n} = 2'h3;
		cyc(3);
		chk(cfg_ok, 0);
		wr(0, 8'h00);
		chk(sfr_boot_rdata, 8'hff);
		self_flash_programming(0);
		slow = 0;
		cyc(3);
		chk(cfg_ok, 1);
		chk(sfr_boot_rdata & sfr_bo_rdata & sfr_wd_rdata, 8'hff);
		for (int i = 0; i < 8; i++) begin
			wr(0, 8'(i));
			chk(boot_region_size, 8'(i));
			e = i[2] ? 3'(7 - i) : 3'h4;
			chk(boot_region_kb, e);
			chk(app_region_kb, 8'h12 - e);
		end
		erase = 0;
		{arst_n, por_rst_n} = 2'h0;
		cyc(2);
		{arst_n, por_rst_n} = 2'h3;
		cyc(3);
		chk(sfr_bo_rdata, 8'hcf);
		chk(boot_region_kb, 3'h2);
		chk({brownout_detect_on, brownout_threshold_select}, 3'h4);
		chk({brownout_blocks_flash_write, brownout_reset_on}, 2'h3);
		brownout_pin = 1;
		cyc(4);
		chk({flash_write_ok, brownout_reset_req}, 2'h1);
		self_flash_programming(0);
		wr(1, 8'h88);
		chk(brownout_reset_req, 0);
		wr(1, 8'h08);
		chk({brownout_detect_on, flash_write_ok}, 2'h1);
		self_flash_programming(1);
		for (int t = 0; t < 4; t++) begin
			wr(1, 8'h80 | 8'(t << 4));
			chk(brownout_threshold_select, 8'(t));
			chk(flash_write_ok, 1);
		end
		self_flash_programming(1);
		core_idle = 1;
		for (int w = 0; w < 16; w++) begin
			wr(2, 8'(w << 4));
			chk(watchdog_startup_mode, 8'(w));
			chk({wdt_general_timer, wdt_reset_on}, {w == 15, w != 15});
			chk({wdt_stop_in_idle, wdt_count_en}, {w == 5, w != 5});
		end
		wr(1, 8'h00);
		wr(0, 8'h07);
		arst_n = 0;
		cyc(2);
		arst_n = 1;
		cyc(3);
		chk(sfr_bo_rdata, 8'h43);
		chk(boot_region_kb, 3'h2);
		chk(sfr_wd_rdata, 8'h5f);
		summarize();
	end
endmodule
`default_nettype wire
